// *** shared/pmic_regs_pkg.sv ***
/*
 * Constants and types for the supply-controller register bank: frame field positions,
 * register addresses, reset values, disable pair positions, key words and carriers.
 * Assumes a 16-bit serial frame, address in the top five bits, odd parity in bit 0.
 */
package pmic_regs_pkg;

    // frame layout
    localparam int FRAME_BITS = 16;
    localparam int ADDR_HI = 15;
    localparam int ADDR_LO = 11;
    localparam int WR_BIT = 10;
    localparam int DATA_HI = 8;
    localparam int DATA_LO = 1;
    localparam int PARITY_BIT = 0;
    localparam int RESP_FF_BIT = 15;
    localparam logic [4:0] CNT_FULL = 5'h10;
    localparam logic [4:0] CNT_MAX = 5'h11;

    // register addresses
    localparam logic [4:0] ADDR_STATUS0 = 5'h00;
    localparam logic [4:0] ADDR_STATUS1 = 5'h01;
    localparam logic [4:0] ADDR_STATUS2 = 5'h02;
    localparam logic [4:0] ADDR_DIAG0 = 5'h03;
    localparam logic [4:0] ADDR_DIAG1 = 5'h04;
    localparam logic [4:0] ADDR_DIAG2 = 5'h05;
    localparam logic [4:0] ADDR_DISABLE = 5'h06;
    localparam logic [4:0] ADDR_KEY = 5'h07;
    localparam logic [4:0] ADDR_CFG0 = 5'h08;
    localparam logic [4:0] ADDR_CFG1 = 5'h09;
    localparam logic [4:0] ADDR_VERIFY0 = 5'h0a;

    // reset values: every rail undervoltage latched at power-up
    localparam logic [7:0] DIAG0_RESET = 8'h55;
    localparam logic [7:0] DIAG1_RESET = 8'h55;
    localparam logic [7:0] DIAG2_RESET = 8'h75;
    localparam logic [7:0] DIAG2_EVT_MASK = 8'h07;
    localparam logic [7:0] DIAG2_OK_MASK = 8'h70;
    localparam logic [7:0] DISABLE_RESET = 8'h00;
    localparam logic [7:0] CFG0_RESET = 8'h00;
    localparam logic [7:0] CFG1_RESET = 8'h00;
    localparam logic [7:0] CFG1_MASK = 8'h1f;
    localparam logic [7:0] VERIFY_RESET = 8'h00;

    // disable pairs: upper bit, partner sits four below
    localparam int PAIR_SPAN = 4;
    localparam int PAIR_PROT = 7;
    localparam int PAIR_A = 6;
    localparam int PAIR_B = 5;
    localparam int PAIR_TRX = 4;

    // key words, values arbitrary
    localparam logic [7:0] FLASH_KEY0 = 8'h3c;
    localparam logic [7:0] FLASH_KEY1 = 8'hc3;
    localparam logic [7:0] FLASH_KEY2 = 8'h5a;
    localparam logic [7:0] RESTART_KEY0 = 8'h69;
    localparam logic [7:0] RESTART_KEY1 = 8'h96;
    localparam logic [7:0] RESTART_KEY2 = 8'ha5;

    typedef enum logic [2:0] {
        KEY_WAIT1 = 3'b001,
        KEY_WAIT2 = 3'b010,
        KEY_WAIT3 = 3'b100
    } key_state_t;

    typedef struct packed {
        logic [6:0] health0;     // status0 bits 6:0, one = healthy
        logic [6:0] health1;     // status1 bits 6:0, bit 5 = watchdog_fault
        logic [7:0] supervisor;  // status2 as shown
        logic [7:0] diag0_evt;   // one = fault present
        logic [7:0] diag1_evt;
        logic [7:0] diag2_evt;   // bits 6:4 and 2:0, one = fault present
        logic selftest_active;
    } monitor_in_t;

    typedef struct packed {
        logic [3:0] rail_off;    // 3 protected, 2 rail a, 1 rail b, 0 transceiver
        logic flash_mode;
        logic wd_restart;
        logic [1:0] wd_period_select;
        logic [2:0] adjust_a;
        logic [2:0] adjust_b;
        logic dither_off;
        logic [1:0] valid_count;
        logic [1:0] edge_count;
    } control_out_t;

endpackage : pmic_regs_pkg

// *** rtl/pmic_status_diag_control_regs.sv ***
/*
 * Register bank of a multi-rail supply controller reached over a 16-bit strobed serial
 * link: status, latching diagnostics, output disable pairs, watchdog key entry,
 * watchdog/dither configuration and self-test results.
 * Assumes the host holds sck high while str_n changes and that sck runs only in frames.
 */
// Behaviour
// R1: diagnostic bits latch until software clears
// R2: writing one clears a diagnostic bit
// R3: startup latches undervoltage on every rail
// R4: host clears diagnostics after startup
// R5: disable needs both pair bits set
// R6: pairs 7/3, 6/2, 5/1, 4/0
// R7: transceiver stays off until cleared and restarted
// R8: three ordered key words enter modes
// R9: wrong key word restarts the sequence
// R10: only restart sequence leaves flash mode
// R11: restart keeps stored configuration values
// R12: self-test toggle latches verify bit high
// R13: status0 fault flag and health bits
// R14: status1 bit5 watchdog fault, others health
// R15: status2 bits 7/6 input stuck
// R16: status2 bits 2:0 watchdog state
// R17: status2 bits 5/4/3 pin levels
// R18: diag2 bits 6/5/4 switch and diode health
// R19: config0 period, adjust_a, adjust_b fields
// R20: config1 bit4 turns dithering off
// R21: config1 valid threshold and edge count
// R22: frame bits 15:11 carry address
// R23: frame bit 10 selects write
// R24: frame bits 8:1 carry data
// R25: frame bit 0 gives odd parity
// R26: undefined bits read zero, status ignores writes
// R27: reset restores defaults and key tracker
`timescale 1ns/1ps
module pmic_status_diag_control_regs (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic sck_in,
    input wire logic sdi_in,
    input wire logic str_n_in,
    input wire pmic_regs_pkg::monitor_in_t monitor_in,
    output logic sdo_out,
    output logic sdo_oe_out,
    output logic serial_error_out,
    output logic fault_flag_out,
    output pmic_regs_pkg::control_out_t control_out
);
    import pmic_regs_pkg::*;

    function automatic logic pair_on(input logic [7:0] r, input int hi);
        pair_on = r[hi] & r[hi - PAIR_SPAN];
    endfunction : pair_on

    // ---------------- link domain (sck) ----------------
    logic fresh_reg;
    logic [15:0] shift_reg;
    logic [15:0] shift_next;
    logic [4:0] cnt_reg;
    logic [4:0] cnt_next;
    logic [15:0] resp_reg;
    logic [3:0] sdo_idx;

    // marks a new frame; set while strobe is high, gone at first sck rising edge
    always_ff @(posedge sck_in or posedge str_n_in) begin
        if (str_n_in) begin
            fresh_reg <= 1'b1;
        end else begin
            fresh_reg <= 1'b0;
        end
    end

    always_comb begin
        shift_next = {shift_reg[14:0], sdi_in};
        if (fresh_reg) begin
            cnt_next = 5'h01;
        end else if (cnt_reg == CNT_MAX) begin
            cnt_next = cnt_reg;
        end else begin
            cnt_next = cnt_reg + 5'h01;
        end
    end

    always_ff @(posedge sck_in) begin
        shift_reg <= shift_next;
        cnt_reg <= cnt_next;
    end

    // answer word changes in the core only between frames, after the strobe rises
    always_comb begin
        if (fresh_reg || cnt_reg >= CNT_FULL) begin
            sdo_idx = fresh_reg ? 4'hf : 4'h0;
        end else begin
            sdo_idx = 4'hf - cnt_reg[3:0];
        end
    end
    assign sdo_out = str_n_in ? 1'b0 : resp_reg[sdo_idx];
    assign sdo_oe_out = ~str_n_in;

    // ---------------- core domain (ref_clk) ----------------
    logic str_meta_reg;
    logic str_sync_reg;
    logic str_prev_reg;
    monitor_in_t mon_meta_reg;
    monitor_in_t mon_reg;
    logic [7:0] evt0_prev_reg;

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            str_meta_reg <= 1'b1;
            str_sync_reg <= 1'b1;
            str_prev_reg <= 1'b1;
            mon_meta_reg <= '0;
            mon_reg <= '0;
            evt0_prev_reg <= 8'h00;
        end else begin
            str_meta_reg <= str_n_in;
            str_sync_reg <= str_meta_reg;
            str_prev_reg <= str_sync_reg;
            mon_meta_reg <= monitor_in;
            mon_reg <= mon_meta_reg;
            evt0_prev_reg <= mon_reg.diag0_evt;
        end
    end

    logic frame_end;
    logic frame_good;
    logic wr_en;
    logic [4:0] addr;
    logic [7:0] wdata;

    assign frame_end = str_sync_reg & ~str_prev_reg;
    assign frame_good = (cnt_reg == CNT_FULL) && (^shift_reg);       // R25
    assign addr = shift_reg[ADDR_HI:ADDR_LO];                         // R22
    assign wdata = shift_reg[DATA_HI:DATA_LO];                        // R24
    assign wr_en = frame_end & frame_good & shift_reg[WR_BIT];        // R23

    logic [7:0] diag0_reg, diag0_next;
    logic [7:0] diag1_reg, diag1_next;
    logic [7:0] diag2_reg, diag2_next;
    logic [7:0] disable_reg, disable_next;
    logic [7:0] cfg0_reg, cfg0_next;
    logic [7:0] cfg1_reg, cfg1_next;
    logic [7:0] verify_reg, verify_next;
    logic trx_off_reg, trx_off_next;
    logic flash_reg, flash_next;
    logic restart_reg, restart_next;
    logic seq_restart_reg, seq_restart_next;
    key_state_t key_state_reg, key_state_next;
    logic [3:0] rail_off_reg, rail_off_next;
    logic ff_reg, ff_next;
    logic serr_reg, serr_next;
    logic [15:0] resp_next;
    logic [7:0] clr0, clr1, clr2, clr_v, verify_set, rdata, expect_word;
    logic key_wr;
    logic [14:0] resp_body;

    always_comb begin
        clr0 = (wr_en && addr == ADDR_DIAG0) ? wdata : 8'h00;
        clr1 = (wr_en && addr == ADDR_DIAG1) ? wdata : 8'h00;
        clr2 = (wr_en && addr == ADDR_DIAG2) ? wdata : 8'h00;
        clr_v = (wr_en && addr == ADDR_VERIFY0) ? wdata : 8'h00;
        key_wr = wr_en && addr == ADDR_KEY;
        // a fault arriving with its clear stays set
        diag0_next = (diag0_reg & ~clr0) | mon_reg.diag0_evt;          // R1 R2
        diag1_next = (diag1_reg & ~clr1) | mon_reg.diag1_evt;          // R1 R2
        diag2_next = (((diag2_reg & ~clr2) | mon_reg.diag2_evt) & DIAG2_EVT_MASK)
                   | (((diag2_reg | clr2) & ~mon_reg.diag2_evt) & DIAG2_OK_MASK); // R18
        verify_set = mon_reg.diag0_evt & ~evt0_prev_reg & {8{mon_reg.selftest_active}};
        verify_next = (verify_reg & ~clr_v) | verify_set;               // R12
        ff_next = (|diag0_next) | (|diag1_next) | (|(diag2_next & DIAG2_EVT_MASK))
                | (|(~diag2_next & DIAG2_OK_MASK));
        // status registers ignore writes: no path below touches them
        disable_next = (wr_en && addr == ADDR_DISABLE) ? wdata : disable_reg;   // R26
        cfg0_next = (wr_en && addr == ADDR_CFG0) ? wdata : cfg0_reg;            // R19
        cfg1_next = (wr_en && addr == ADDR_CFG1) ? (wdata & CFG1_MASK) : cfg1_reg; // R21 R26
    end

    // key tracker
    always_comb begin
        key_state_next = key_state_reg;
        seq_restart_next = seq_restart_reg;
        flash_next = flash_reg;
        restart_next = 1'b0;
        expect_word = 8'h00;
        case (key_state_reg)
            KEY_WAIT1: begin
                if (key_wr && wdata == FLASH_KEY0) begin
                    key_state_next = KEY_WAIT2;                         // R8
                    seq_restart_next = 1'b0;
                end else if (key_wr && wdata == RESTART_KEY0) begin
                    key_state_next = KEY_WAIT2;                         // R8
                    seq_restart_next = 1'b1;
                end
            end
            KEY_WAIT2: begin
                expect_word = seq_restart_reg ? RESTART_KEY1 : FLASH_KEY1;
                if (key_wr) begin
                    key_state_next = (wdata == expect_word) ? KEY_WAIT3 : KEY_WAIT1; // R9
                end
            end
            KEY_WAIT3: begin
                expect_word = seq_restart_reg ? RESTART_KEY2 : FLASH_KEY2;
                if (key_wr) begin
                    key_state_next = KEY_WAIT1;                         // R9
                    if (wdata == expect_word && seq_restart_reg) begin
                        flash_next = 1'b0;                              // R10
                        restart_next = 1'b1;                            // R11
                    end else if (wdata == expect_word) begin
                        flash_next = 1'b1;                              // R8
                    end
                end
            end
            default: begin
                key_state_next = KEY_WAIT1;
            end
        endcase
    end

    // disable pairs; transceiver rail stays off until pair cleared and restart
    always_comb begin
        if (pair_on(disable_next, PAIR_TRX)) begin
            trx_off_next = 1'b1;
        end else if (restart_next && !disable_next[PAIR_TRX]
                     && !disable_next[PAIR_TRX - PAIR_SPAN]) begin
            trx_off_next = 1'b0;                                        // R7
        end else begin
            trx_off_next = trx_off_reg;                                 // R7
        end
        rail_off_next = {pair_on(disable_next, PAIR_PROT),              // R5 R6
                         pair_on(disable_next, PAIR_A),
                         pair_on(disable_next, PAIR_B),
                         trx_off_next};
    end

    // read mux and answer word for the next frame
    always_comb begin
        case (addr)
            ADDR_STATUS0: rdata = {ff_reg, mon_reg.health0};           // R13
            ADDR_STATUS1: rdata = {1'b0, mon_reg.health1};             // R14
            ADDR_STATUS2: rdata = mon_reg.supervisor;                  // R15 R16 R17
            ADDR_DIAG0: rdata = diag0_reg;
            ADDR_DIAG1: rdata = diag1_reg;
            ADDR_DIAG2: rdata = diag2_reg;
            ADDR_DISABLE: rdata = disable_reg;
            ADDR_CFG0: rdata = cfg0_reg;
            ADDR_CFG1: rdata = cfg1_reg;
            ADDR_VERIFY0: rdata = verify_reg;
            default: rdata = 8'h00;                                     // R26
        endcase
        // data sits in 8:1 like the request; parity covers every sent bit
        if (shift_reg[WR_BIT]) begin
            resp_body = {ff_reg, addr, 1'b0, diag0_reg};                // R24
            resp_next = {resp_body, ~^resp_body};                       // R25
        end else begin
            resp_body = {ff_reg, addr, 1'b0, rdata};                    // R24
            resp_next = {resp_body, ~^resp_body};                       // R25
        end
        if (!(frame_end && frame_good)) begin
            resp_next = resp_reg;
        end
        serr_next = frame_end ? ~frame_good : serr_reg;
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            diag0_reg <= DIAG0_RESET;                                   // R3 R27
            diag1_reg <= DIAG1_RESET;                                   // R3 R27
            diag2_reg <= DIAG2_RESET;                                   // R3 R27
            disable_reg <= DISABLE_RESET;
            cfg0_reg <= CFG0_RESET;
            cfg1_reg <= CFG1_RESET;
            verify_reg <= VERIFY_RESET;
            trx_off_reg <= 1'b0;
            flash_reg <= 1'b0;
            restart_reg <= 1'b0;
            seq_restart_reg <= 1'b0;
            key_state_reg <= KEY_WAIT1;                                 // R27
            rail_off_reg <= 4'h0;
            ff_reg <= 1'b1;
            serr_reg <= 1'b0;
            resp_reg <= 16'h0000;
        end else begin
            diag0_reg <= diag0_next;
            diag1_reg <= diag1_next;
            diag2_reg <= diag2_next;
            disable_reg <= disable_next;
            cfg0_reg <= cfg0_next;
            cfg1_reg <= cfg1_next;
            verify_reg <= verify_next;
            trx_off_reg <= trx_off_next;
            flash_reg <= flash_next;
            restart_reg <= restart_next;
            seq_restart_reg <= seq_restart_next;
            key_state_reg <= key_state_next;
            rail_off_reg <= rail_off_next;
            ff_reg <= ff_next;
            serr_reg <= serr_next;
            resp_reg <= resp_next;
        end
    end

    assign serial_error_out = serr_reg;
    assign fault_flag_out = ff_reg;
    assign control_out.rail_off = rail_off_reg;
    assign control_out.flash_mode = flash_reg;
    assign control_out.wd_restart = restart_reg;
    assign control_out.wd_period_select = cfg0_reg[7:6];               // R19
    assign control_out.adjust_a = cfg0_reg[5:3];                        // R19
    assign control_out.adjust_b = cfg0_reg[2:0];                        // R19
    assign control_out.dither_off = cfg1_reg[4];                        // R20
    assign control_out.valid_count = cfg1_reg[3:2];                     // R21
    assign control_out.edge_count = cfg1_reg[1:0];                      // R21

    // ---------------- checks ----------------
    a_diag_latch_hold: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R1
        !(wr_en && addr == ADDR_DIAG0) |=> (diag0_reg & $past(diag0_reg)) == $past(diag0_reg))
        else $error("diag0 bit dropped without a clear");

    a_diag_w1c_clear: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R2
        (wr_en && addr == ADDR_DIAG1) |=> (diag1_reg & $past(wdata) & ~$past(mon_reg.diag1_evt))
            == 8'h00)
        else $error("diag1 write of one did not clear");

    a_startup_uv_latched: assert property (@(posedge ref_clk_in) // R3
        $fell(rst_in) |-> ((diag0_reg & DIAG0_RESET) == DIAG0_RESET)
            && ((diag1_reg & DIAG1_RESET) == DIAG1_RESET) && key_state_reg == KEY_WAIT1)
        else $error("startup undervoltage not latched");

    a_pair_disable_map: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R5
        ##1 control_out.rail_off[3:1] == {disable_reg[7] & disable_reg[3],
            disable_reg[6] & disable_reg[2], disable_reg[5] & disable_reg[1]})
        else $error("rail disable does not follow its pair");

    a_trx_stays_off: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R7
        (trx_off_reg && !restart_next) |=> trx_off_reg)
        else $error("transceiver rail re-enabled without restart");

    a_key_wrong_word: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R9
        (key_state_reg == KEY_WAIT2 && key_wr && wdata != expect_word)
            |=> key_state_reg == KEY_WAIT1 && $stable(flash_reg))
        else $error("wrong key word did not restart sequence");

    a_flash_exit_key: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R10
        $fell(flash_reg) |-> $past(key_state_reg == KEY_WAIT3 && seq_restart_reg && key_wr)
            && restart_reg)
        else $error("flash mode left without restart sequence");

    a_bad_frame_reject: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R25
        (frame_end && !frame_good) |=> serr_reg && $stable(cfg0_reg) && $stable(disable_reg))
        else $error("bad frame changed registers");

    a_verify_set_high: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R12
        (verify_set != 8'h00) |=> (verify_reg & $past(verify_set)) == $past(verify_set))
        else $error("self-test toggle did not latch verify bit");

    a_restart_keeps_cfg: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R11
        restart_reg |-> $stable(cfg0_reg) && $stable(cfg1_reg))
        else $error("restart changed stored configuration");

    a_flash_key_enter: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R8
        (key_state_reg == KEY_WAIT3 && key_wr && !seq_restart_reg && wdata == FLASH_KEY2)
            |=> flash_reg)
        else $error("flash sequence did not enter flash mode");

    a_unmapped_read_zero: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R26
        (addr > ADDR_VERIFY0) |-> rdata == 8'h00)
        else $error("unmapped address read nonzero");

    a_trx_pair_off: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R7
        (disable_reg[PAIR_TRX] && disable_reg[PAIR_TRX - PAIR_SPAN]) |-> control_out.rail_off[0])
        else $error("transceiver rail on with its pair set");

    a_answer_odd_parity: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R25
        (resp_reg != 16'h0000) |-> ^resp_reg)
        else $error("answer word parity not odd");

    a_serr_good_frame: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R25
        (frame_end && frame_good) |=> !serr_reg)
        else $error("good frame left serial error set");

endmodule : pmic_status_diag_control_regs

// *** tb/spi_host_model.sv ***
/*
 * Host side of the strobed 16-bit serial link: one frame per xfer call.
 * Assumes nothing else drives the link; sck idles low and runs only in frames.
 */
`timescale 1ns/1ps
module spi_host_model (
    output logic sck_out,
    output logic sdi_out,
    output logic str_n_out,
    input wire logic sdo_in
);
    initial begin
        sck_out = 1'b0;
        sdi_out = 1'b0;
        str_n_out = 1'b1;
    end

    // n other than 16 or bad_par set makes a frame the device must refuse
    task automatic xfer(input logic [4:0] a, input logic wr, input logic [7:0] d,
                        input int n, input logic bad_par, output logic [15:0] rx);
        logic [15:0] w;
        w = {a, wr, 1'b0, d, 1'b0};
        w[0] = ~^w[15:1] ^ bad_par;
        rx = 16'h0000;
        sck_out = 1'b1;
        #32;
        str_n_out = 1'b0;
        #32;
        for (int i = 0; i < n; i++) begin
            sck_out = 1'b0;
            sdi_out = (i < 16) ? w[15 - i] : 1'b0;
            #32;
            if (i < 16) rx[15 - i] = sdo_in;
            sck_out = 1'b1;
            #32;
        end
        str_n_out = 1'b1;
        #32;
        sck_out = 1'b0;
        sdi_out = 1'b0;
        #100;
    endtask : xfer
endmodule : spi_host_model

// *** tb/tb_pmic_status_diag_control_regs.sv ***
/*
 * Self-checking bench for the supply-controller register bank.
 * Assumes the host model in spi_host_model.sv and the shared package.
 */
`timescale 1ns/1ps
module tb_pmic_status_diag_control_regs;
    import pmic_regs_pkg::*;
    logic clk, rst, sck, sdi, str_n, sdo, sdo_oe, serr, ff;
    monitor_in_t mon;
    control_out_t ctl;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;
    int pulses = 0;
    logic [7:0] dv [6] = '{8'h08, 8'h80, 8'h88, 8'h44, 8'h22, 8'h11};
    logic [3:0] dx [6] = '{4'h0, 4'h0, 4'h8, 4'h4, 4'h2, 4'h1};

    spi_host_model host (.sck_out(sck), .sdi_out(sdi), .str_n_out(str_n), .sdo_in(sdo));
    pmic_status_diag_control_regs DUT (.ref_clk_in(clk), .rst_in(rst), .sck_in(sck),
        .sdi_in(sdi), .str_n_in(str_n), .monitor_in(mon), .sdo_out(sdo),
        .sdo_oe_out(sdo_oe), .serial_error_out(serr), .fault_flag_out(ff),
        .control_out(ctl));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (!rst && ctl.wd_restart === 1'b1) pulses <= pulses + 1;
        if (cycles == 40000) begin
            err_total++;
            results();
        end
    end

    task automatic results;
        $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : results

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [15:0] rx;
        host.xfer(a, 1'b1, d, 16, 1'b0, rx);
    endtask : wr

    // the answer to a read comes back in the following frame
    task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
        logic [15:0] rx;
        host.xfer(a, 1'b0, 8'h00, 16, 1'b0, rx);
        host.xfer(a, 1'b0, 8'h00, 16, 1'b0, rx);
        chk(rx[8:1], exp);
        chk(rx[14:10], a);
        chk(^rx, 1'b1);
    endtask : rchk

    task automatic keys(input logic [7:0] k0, input logic [7:0] k1, input logic [7:0] k2);
        wr(ADDR_KEY, k0);
        wr(ADDR_KEY, k1);
        wr(ADDR_KEY, k2);
    endtask : keys

    task automatic ev(input logic [7:0] d0, input logic [7:0] d2, input logic st);
        @(negedge clk);
        mon.diag0_evt = d0;
        mon.diag2_evt = d2;
        mon.selftest_active = st;
        repeat (6) @(negedge clk);
    endtask : ev

    task automatic t_reset;
        rchk(ADDR_DIAG0, DIAG0_RESET);
        rchk(ADDR_DIAG1, DIAG1_RESET);
        rchk(ADDR_DIAG2, DIAG2_RESET);
        rchk(ADDR_DISABLE, 8'h00);
        rchk(ADDR_CFG0, 8'h00);
        rchk(ADDR_CFG1, 8'h00);
        rchk(ADDR_VERIFY0, 8'h00);
        chk(ff, 1'b1);
        $display("test reset done");
    endtask : t_reset

    task automatic t_status;
        @(negedge clk);
        mon.health0 = 7'h2a;
        mon.health1 = 7'h7f;
        mon.supervisor = 8'hc5;
        wr(ADDR_STATUS0, 8'h55);
        rchk(ADDR_STATUS0, 8'haa);
        rchk(ADDR_STATUS1, 8'h7f);
        rchk(ADDR_STATUS2, 8'hc5);
        rchk(5'h0c, 8'h00);
        $display("test status done");
    endtask : t_status

    task automatic t_diag;
        wr(ADDR_DIAG0, 8'hff);
        wr(ADDR_DIAG1, 8'hff);
        wr(ADDR_DIAG2, 8'hff);
        rchk(ADDR_DIAG0, 8'h00);
        rchk(ADDR_DIAG2, 8'h70);
        chk(ff, 1'b0);
        ev(8'h08, 8'h20, 1'b0);
        ev(8'h00, 8'h20, 1'b0);
        rchk(ADDR_DIAG0, 8'h08);
        chk(ff, 1'b1);
        wr(ADDR_DIAG0, 8'h00);
        rchk(ADDR_DIAG0, 8'h08);
        wr(ADDR_DIAG0, 8'h08);
        rchk(ADDR_DIAG0, 8'h00);
        wr(ADDR_DIAG2, 8'h20);
        rchk(ADDR_DIAG2, 8'h50);
        ev(8'h00, 8'h00, 1'b0);
        wr(ADDR_DIAG2, 8'h20);
        rchk(ADDR_DIAG2, 8'h70);
        $display("test diag done");
    endtask : t_diag

    task automatic t_disable;
        for (int i = 0; i < 6; i++) begin
            wr(ADDR_DISABLE, dv[i]);
            chk(ctl.rail_off, dx[i]);
        end
        wr(ADDR_DISABLE, 8'h00);
        rchk(ADDR_DISABLE, 8'h00);
        chk(ctl.rail_off, 4'h1);
        keys(RESTART_KEY0, RESTART_KEY1, RESTART_KEY2);
        chk(ctl.rail_off, 4'h0);
        chk(pulses, 1);
        $display("test disable done");
    endtask : t_disable

    task automatic t_keys;
        wr(ADDR_CFG0, 8'hb5);
        wr(ADDR_CFG1, 8'hf6);
        rchk(ADDR_CFG1, 8'h16);
        chk({ctl.wd_period_select, ctl.adjust_a, ctl.adjust_b}, 8'hb5);
        chk({ctl.dither_off, ctl.valid_count, ctl.edge_count}, 5'h16);
        keys(FLASH_KEY0, 8'h00, FLASH_KEY1);
        wr(ADDR_KEY, FLASH_KEY2);
        chk(ctl.flash_mode, 1'b0);
        keys(FLASH_KEY0, FLASH_KEY1, FLASH_KEY2);
        chk(ctl.flash_mode, 1'b1);
        keys(RESTART_KEY0, RESTART_KEY1, 8'h00);
        chk(ctl.flash_mode, 1'b1);
        keys(RESTART_KEY0, RESTART_KEY1, RESTART_KEY2);
        chk(ctl.flash_mode, 1'b0);
        chk(pulses, 2);
        rchk(ADDR_CFG0, 8'hb5);
        chk({ctl.dither_off, ctl.valid_count, ctl.edge_count}, 5'h16);
        $display("test keys done");
    endtask : t_keys

    task automatic t_frame;
        logic [15:0] rx;
        host.xfer(ADDR_CFG0, 1'b1, 8'h00, 15, 1'b0, rx);
        chk(serr, 1'b1);
        host.xfer(ADDR_CFG0, 1'b1, 8'h00, 17, 1'b0, rx);
        chk(serr, 1'b1);
        host.xfer(ADDR_CFG0, 1'b1, 8'h00, 16, 1'b1, rx);
        chk(serr, 1'b1);
        fork
            host.xfer(ADDR_CFG0, 1'b0, 8'hff, 16, 1'b0, rx);
            begin
                #200;
                chk(sdo_oe, 1'b1);
            end
        join
        chk(serr, 1'b0);
        chk(sdo_oe, 1'b0);
        rchk(ADDR_CFG0, 8'hb5);
        $display("test frame done");
    endtask : t_frame

    task automatic t_selftest;
        ev(8'h01, 8'h00, 1'b1);
        ev(8'h00, 8'h00, 1'b0);
        rchk(ADDR_VERIFY0, 8'h01);
        wr(ADDR_VERIFY0, 8'h01);
        rchk(ADDR_VERIFY0, 8'h00);
        $display("test selftest done");
    endtask : t_selftest

    task automatic t_rerst;
        wr(ADDR_KEY, FLASH_KEY0);
        @(negedge clk);
        rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        chk(ff, 1'b1);
        wr(ADDR_KEY, FLASH_KEY1);
        wr(ADDR_KEY, FLASH_KEY2);
        chk(ctl.flash_mode, 1'b0);
        rchk(ADDR_CFG0, 8'h00);
        $display("test second reset done");
    endtask : t_rerst

    initial begin
        rst = 1'b1;
        mon = '0;
        mon.health0 = 7'h7f;
        mon.health1 = 7'h5f;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_status();
        t_diag();
        t_disable();
        t_keys();
        t_frame();
        t_selftest();
        t_rerst();
        results();
    end
endmodule : tb_pmic_status_diag_control_regs
